// file: rtl/sps_speed_setpoint_channel.sv
// Speed setpoint channel: fixed setpoints, shaping chain, ramp, APB slave.
//
// Behaviour
// - Fixed source code routes fixed result to main
// - Fixed source code routes fixed result to supplementary
// - Up to sixteen fixed setpoint results selectable
// - Direct mode sums four gated fixed values
// - Binary mode picks one of sixteen values
// - Mode setting one selects direct summing
// - Selection bits each taken from assigned source
// - Inversion signal one negates the setpoint
// - Inversion connectable to control word bit 11
// - Both directions allowed after reset
// - Negative inhibit blocks negative setpoints
// - Positive inhibit blocks positive setpoints
// - No steady setpoint below minimum speed; the later clamps, double inhibit and run off can still go below it
// - Clamp magnitude to maximum speed, default 1500
// - Flag when actual speed exceeds maximum
// - Positive limit, default 210000 rpm
// - Negative limit, default minus 210000 rpm
// - Maximum speed is the ramp reference
// - Ramp limits setpoint change per tick
// - Technology controller source bypasses the ramp
// - Extended ramp limits acceleration and jerk
// - Basic ramp limits acceleration only
// - Ramp type zero basic, one extended, default extended
// - Ramp-up time zero to maximum, default 10 s
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
module sps_speed_setpoint_channel #(
    parameter int TICK_CYCLES = sps_pkg::TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] digitalIn,
    input wire logic [15:0] fieldbusCtrl,
    input wire logic [31:0] fieldbusSetpoint,
    input wire logic techCtrlActive,
    input wire logic [31:0] techSetpoint,
    input wire logic [31:0] actualSpeed,
    output logic [31:0] mainSetpoint,
    output logic [31:0] suppSetpoint,
    output logic [31:0] speedSetpoint,
    output logic overspeedAlarm
);
    sps_pkg::sps_state_t st;
    sps_pkg::sps_state_t next_st;
    logic [3:0] selBits;
    logic runSig;
    logic mapped;
    logic apbWrite;
    logic divBusy;
    logic divDone;
    logic [47:0] divQuot;

    // Zero wait states; a low clock enable stretches the access phase.
    assign pready = clkEn;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= sps_pkg::OFF_TARGET
        || (paddr >= sps_pkg::OFF_FIXED && paddr <= sps_pkg::OFF_FIXED_LAST));
    assign pslverr = psel && penable && !mapped;
    assign apbWrite = psel && penable && pwrite && mapped;

    always_comb
    begin
        for (int i = 0; i < sps_pkg::SEL_BITS; i++)
            selBits[i] = st.ctrl[sps_pkg::CTRL_SEL_SRC + i] ? fieldbusCtrl[i]
                : st.dinSync[i];
        runSig = st.ctrl[sps_pkg::CTRL_RUN_BUS]
            ? fieldbusCtrl[sps_pkg::CW_RUN_BIT]
            : st.dinSync[sps_pkg::DIN_RUN];
    end

    // Continuous recompute keeps the rate current after any config write.
    sps_divider i_sps_divider (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .start(!divBusy),
        .dividend({st.maxSpd, 16'h0000}),
        .divisor(st.rampMs),
        .busy(divBusy),
        .done(divDone),
        .quotient(divQuot)
    );

    always_comb
    begin
        logic signed [31:0] fixedRes;
        logic signed [31:0] v;
        logic signed [31:0] minS;
        logic signed [31:0] maxS;
        logic signed [31:0] act;
        logic invSig;
        logic negInh;
        logic posInh;
        logic signed [48:0] diff;
        logic [48:0] absDiff;
        logic [47:0] step;
        logic [47:0] jStep;
        logic [47:0] accUp;
        next_st = st;
        fixedRes = '0;
        v = '0;
        minS = $signed(st.minSpd);
        maxS = $signed(st.maxSpd);
        act = $signed(actualSpeed);
        invSig = 1'b0;
        negInh = st.ctrl[sps_pkg::CTRL_NEG_INH];
        posInh = st.ctrl[sps_pkg::CTRL_POS_INH];
        diff = '0;
        absDiff = '0;
        step = '0;
        jStep = '0;
        accUp = '0;

        next_st.dinMeta = digitalIn;
        next_st.dinSync = st.dinMeta;

        // Read data is captured in the setup cycle.
        if (psel && !penable)
        begin
            if (paddr == sps_pkg::OFF_CTRL)
                next_st.rdata = st.ctrl;
            else if (paddr == sps_pkg::OFF_SRC)
                next_st.rdata = st.src;
            else if (paddr == sps_pkg::OFF_MIN)
                next_st.rdata = st.minSpd;
            else if (paddr == sps_pkg::OFF_MAX)
                next_st.rdata = st.maxSpd;
            else if (paddr == sps_pkg::OFF_POSLIM)
                next_st.rdata = st.posLim;
            else if (paddr == sps_pkg::OFF_NEGLIM)
                next_st.rdata = st.negLim;
            else if (paddr == sps_pkg::OFF_RAMPUP)
                next_st.rdata = st.rampMs;
            else if (paddr == sps_pkg::OFF_STATUS)
                next_st.rdata = {29'h0, runSig,
                    st.rampSp == {st.target, 16'h0000}, st.overspeed};
            else if (paddr == sps_pkg::OFF_SETPOINT)
                next_st.rdata = st.rampSp[47:16];
            else if (paddr == sps_pkg::OFF_TARGET)
                next_st.rdata = st.target;
            else if (mapped)
                next_st.rdata = st.fixedVal[paddr[5:2]];
            else
                next_st.rdata = '0;
        end

        if (apbWrite)
        begin
            if (paddr == sps_pkg::OFF_CTRL)
                next_st.ctrl = {20'h0, pwdata[11:8], 1'b0, pwdata[6:0]};
            else if (paddr == sps_pkg::OFF_SRC)
                next_st.src = pwdata;
            else if (paddr == sps_pkg::OFF_MIN)
                next_st.minSpd = pwdata;
            else if (paddr == sps_pkg::OFF_MAX)
                next_st.maxSpd = pwdata;
            else if (paddr == sps_pkg::OFF_POSLIM)
                next_st.posLim = pwdata;
            else if (paddr == sps_pkg::OFF_NEGLIM)
                next_st.negLim = pwdata;
            else if (paddr == sps_pkg::OFF_RAMPUP)
                next_st.rampMs = pwdata;
            else if (paddr == sps_pkg::OFF_STATUS)
            begin
                if (pwdata[sps_pkg::STAT_OVERSPEED])
                    next_st.overspeed = 1'b0;
            end
            else if (paddr >= sps_pkg::OFF_FIXED)
                next_st.fixedVal[paddr[5:2]] = pwdata;
        end

        // A new overspeed event wins over a clear in the same cycle.
        if ((act < 0 ? -act : act) > maxS)
            next_st.overspeed = 1'b1;

        if (st.ctrl[sps_pkg::CTRL_DIRECT])
        begin
            for (int i = 0; i < sps_pkg::SEL_BITS; i++)
                if (selBits[i])
                    fixedRes = fixedRes + $signed(st.fixedVal[i]);
        end
        else
        begin
            // Code zero reads entry 0, which is zero until written.
            fixedRes = $signed(st.fixedVal[selBits]);
        end

        // Sources other than fixed and fieldbus are not part of this block.
        next_st.mainSp = (st.src[15:0] == sps_pkg::FIXED_SOURCE_CODE)
            ? fixedRes : fieldbusSetpoint;
        next_st.suppSp = (st.src[31:16] == sps_pkg::FIXED_SOURCE_CODE)
            ? fixedRes : 32'h0000_0000;

        // Shaping chain in its fixed order.
        v = $signed(st.mainSp) + $signed(st.suppSp);
        invSig = st.ctrl[sps_pkg::CTRL_INV_EN]
            && (st.ctrl[sps_pkg::CTRL_INV_BUS]
            ? fieldbusCtrl[sps_pkg::CW_INVERT_BIT]
            : st.dinSync[sps_pkg::DIN_INVERT]);
        if (invSig)
            v = -v;
        if (negInh && v < 0)
            v = '0;
        if (posInh && v > 0)
            v = '0;
        if ((v < 0 ? -v : v) < minS)
            v = (v < 0 || posInh) ? -minS : minS;
        if (negInh && posInh)
            v = '0;
        if (v > maxS)
            v = maxS;
        if (v < -maxS)
            v = -maxS;
        if (v > $signed(st.posLim))
            v = $signed(st.posLim);
        if (v < $signed(st.negLim))
            v = $signed(st.negLim);
        if (!runSig)
            v = '0;
        next_st.target = v;

        if (divDone)
            next_st.accMax = divQuot[47] ? sps_pkg::ACC_CEIL : divQuot;

        next_st.tick = 1'b0;
        if (st.tickCnt == 16'(TICK_CYCLES - 1))
        begin
            next_st.tickCnt = '0;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.tickCnt = st.tickCnt + 16'h0001;
        end

        diff = $signed({st.target[31], st.target, 16'h0000})
            - $signed({st.rampSp[47], st.rampSp});
        absDiff = diff < 0 ? 49'(-diff) : 49'(diff);
        jStep = (st.accMax >> sps_pkg::JERK_SHIFT) | 48'h1;
        accUp = st.curAcc + jStep;
        if (st.ctrl[sps_pkg::CTRL_RAMP_EXT])
            step = st.curAcc;
        else
            step = st.accMax;

        if (techCtrlActive)
        begin
            next_st.rampSp = {techSetpoint, 16'h0000};
            next_st.curAcc = '0;
        end
        else if (st.tick)
        begin
            if (absDiff <= {1'b0, step})
            begin
                next_st.rampSp = {st.target, 16'h0000};
                next_st.curAcc = '0;
            end
            else
            begin
                next_st.rampSp = diff < 0 ? st.rampSp - step
                    : st.rampSp + step;
                // Acceleration itself rises gradually in the extended ramp.
                next_st.curAcc = (accUp > st.accMax) ? st.accMax : accUp;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.ctrl <= sps_pkg::CTRL_RESET;
            st.src <= sps_pkg::SRC_RESET;
            st.minSpd <= sps_pkg::MIN_RESET;
            st.maxSpd <= sps_pkg::MAX_RESET;
            st.posLim <= sps_pkg::POSLIM_RESET;
            st.negLim <= sps_pkg::NEGLIM_RESET;
            st.rampMs <= sps_pkg::RAMPUP_RESET;
        end
        else if (clkEn)
        begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign mainSetpoint = st.mainSp;
    assign suppSetpoint = st.suppSp;
    assign speedSetpoint = st.rampSp[47:16];
    assign overspeedAlarm = st.overspeed;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    AST_MAX_CLAMP: assert property ($past(clkEn) |->
        $signed(st.target) <= $signed($past(st.maxSpd)))
        else $error("Target above maximum speed.");
    AST_POS_LIMIT: assert property ($past(clkEn) |->
        $signed(st.target) <= $signed($past(st.posLim)))
        else $error("Target above positive limit.");
    AST_NEG_LIMIT: assert property ($past(clkEn) &&
        $signed($past(st.negLim)) <= $signed($past(st.posLim)) |->
        $signed(st.target) >= $signed($past(st.negLim)))
        else $error("Target below negative limit.");
    AST_NEG_INHIBIT: assert property ($past(clkEn) &&
        $past(st.ctrl[sps_pkg::CTRL_NEG_INH]) |-> !st.target[31])
        else $error("Negative target while inhibited.");
    AST_POS_INHIBIT: assert property ($past(clkEn) &&
        $past(st.ctrl[sps_pkg::CTRL_POS_INH]) |-> $signed(st.target) <= 0)
        else $error("Positive target while inhibited.");
    AST_OVERSPEED: assert property (clkEn &&
        $signed(actualSpeed) > $signed(st.maxSpd) ##1 clkEn
        && $signed(actualSpeed) > $signed(st.maxSpd)
        |-> overspeedAlarm[*2])
        else $error("Overspeed not flagged and held.");
    AST_RAMP_STEP: assert property ($past(clkEn) &&
        !$past(techCtrlActive) |->
        $signed(st.rampSp) - $signed($past(st.rampSp))
        <= $signed($past(st.accMax)) && $signed($past(st.rampSp))
        - $signed(st.rampSp) <= $signed($past(st.accMax)))
        else $error("Ramp step exceeds acceleration.");
    AST_BYPASS: assert property ($past(clkEn) &&
        $past(techCtrlActive) |-> speedSetpoint == $past(techSetpoint))
        else $error("Ramp not bypassed for technology source.");
    AST_BINARY_SEL: assert property ($past(clkEn) &&
        !$past(st.ctrl[sps_pkg::CTRL_DIRECT]) &&
        $past(st.src[15:0]) == sps_pkg::FIXED_SOURCE_CODE |->
        mainSetpoint == $past(st.fixedVal[selBits]))
        else $error("Binary fixed selection wrong.");
endmodule

// file: rtl/sps_pkg.sv
// Package with register map, reset values, timing constants and state types.
package sps_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SRC = 8'h04;
    localparam logic [7:0] OFF_MIN = 8'h08;
    localparam logic [7:0] OFF_MAX = 8'h0c;
    localparam logic [7:0] OFF_POSLIM = 8'h10;
    localparam logic [7:0] OFF_NEGLIM = 8'h14;
    localparam logic [7:0] OFF_RAMPUP = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    localparam logic [7:0] OFF_SETPOINT = 8'h20;
    localparam logic [7:0] OFF_TARGET = 8'h24;
    localparam logic [7:0] OFF_FIXED = 8'h40;
    localparam logic [7:0] OFF_FIXED_LAST = 8'h7c;
    localparam int FIXED_COUNT = 16;
    localparam int SEL_BITS = 4;
    localparam logic [15:0] FIXED_SOURCE_CODE = 16'h0400;
    // Control register field positions.
    localparam int CTRL_DIRECT = 0;
    localparam int CTRL_RAMP_EXT = 1;
    localparam int CTRL_NEG_INH = 2;
    localparam int CTRL_POS_INH = 3;
    localparam int CTRL_INV_BUS = 4;
    localparam int CTRL_INV_EN = 5;
    localparam int CTRL_RUN_BUS = 6;
    localparam int CTRL_SEL_SRC = 8;
    localparam int SRC_SUPP = 16;
    localparam int CW_INVERT_BIT = 11;
    localparam int CW_RUN_BIT = 0;
    localparam int DIN_RUN = 0;
    localparam int DIN_INVERT = 1;
    localparam int STAT_OVERSPEED = 0;
    localparam int STAT_AT_TARGET = 1;
    localparam int STAT_RUN = 2;
    localparam int FRAC_BITS = 16;
    localparam int JERK_SHIFT = 4;
    localparam logic [5:0] DIV_LAST = 6'h2f;
    localparam logic [47:0] ACC_CEIL = 48'h3fff_ffff_ffff;
    // Reset values.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
    localparam logic [31:0] SRC_RESET = 32'h0000_0000;
    localparam logic [31:0] MIN_RESET = 32'h0000_0000;
    localparam logic [31:0] MAX_RESET = 32'h0000_05dc;
    localparam logic [31:0] POSLIM_RESET = 32'h0003_3450;
    localparam logic [31:0] NEGLIM_RESET = 32'hfffc_cbb0;
    localparam int RAMP_UP_TIME_S = 10;
    localparam int MS_PER_S = 1000;
    localparam logic [31:0] RAMPUP_RESET = 32'(RAMP_UP_TIME_S * MS_PER_S);
    // The ramp advances once per millisecond tick.
    localparam int TICK_TIME_NS = 1000000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic busy;
        logic done;
        logic [5:0] cnt;
        logic [47:0] quo;
        logic [32:0] rem;
        logic [31:0] dsr;
        logic [47:0] result;
    } sps_div_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] src;
        logic [31:0] minSpd;
        logic [31:0] maxSpd;
        logic [31:0] posLim;
        logic [31:0] negLim;
        logic [31:0] rampMs;
        logic [FIXED_COUNT-1:0][31:0] fixedVal;
        logic overspeed;
        logic [SEL_BITS-1:0] dinMeta;
        logic [SEL_BITS-1:0] dinSync;
        logic [31:0] mainSp;
        logic [31:0] suppSp;
        logic [31:0] target;
        logic [47:0] rampSp;
        logic [47:0] curAcc;
        logic [47:0] accMax;
        logic [15:0] tickCnt;
        logic tick;
        logic [31:0] rdata;
    } sps_state_t;
endpackage

// file: rtl/sps_divider.sv
// Serial restoring divider used to derive the ramp acceleration.
`timescale 1ns/10ps
module sps_divider (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic start,
    input wire logic [47:0] dividend,
    input wire logic [31:0] divisor,
    output logic busy,
    output logic done,
    output logic [47:0] quotient
);
    sps_pkg::sps_div_t st;
    sps_pkg::sps_div_t next_st;

    always_comb
    begin
        logic [32:0] trial;
        logic qbit;
        next_st = st;
        trial = {st.rem[31:0], st.quo[47]};
        qbit = 1'b0;
        next_st.done = 1'b0;
        if (!st.busy)
        begin
            if (start)
            begin
                next_st.busy = 1'b1;
                next_st.cnt = '0;
                next_st.quo = dividend;
                next_st.rem = '0;
                next_st.dsr = divisor;
            end
        end
        else
        begin
            // A zero divisor yields all ones, which the caller clamps.
            if (trial >= {1'b0, st.dsr})
            begin
                qbit = 1'b1;
                next_st.rem = trial - {1'b0, st.dsr};
            end
            else
            begin
                next_st.rem = trial;
            end
            next_st.quo = {st.quo[46:0], qbit};
            next_st.cnt = st.cnt + 6'h01;
            if (st.cnt == sps_pkg::DIV_LAST)
            begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
                next_st.result = {st.quo[46:0], qbit};
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            st <= '0;
        else if (clkEn)
            st <= next_st;
    end

    assign busy = st.busy;
    assign done = st.done;
    assign quotient = st.result;
endmodule

// file: test/sps_controller_model.sv
// Model of the higher-level controller: digital inputs and fieldbus words.
`timescale 1ns/10ps
module sps_controller_model (
    input wire logic sys_clk,
    input wire logic [3:0] wantDin,
    input wire logic [15:0] wantCw,
    input wire logic [31:0] wantSp,
    output logic [3:0] digitalIn,
    output logic [15:0] fieldbusCtrl,
    output logic [31:0] fieldbusSetpoint
);
    // Commands leave one edge later, as a cyclic telegram would deliver them.
    always_ff @(posedge sys_clk)
    begin
        digitalIn <= wantDin;
        fieldbusCtrl <= wantCw;
        fieldbusSetpoint <= wantSp;
    end
endmodule

// file: test/sps_speed_setpoint_channel_test.sv
// Self-checking testbench of the speed setpoint channel.
`timescale 1ns/10ps
module sps_speed_setpoint_channel_test;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] wantDin = 4'h0;
    logic [15:0] wantCw = 16'h0;
    logic [31:0] wantSp = 32'h0;
    logic [3:0] digitalIn;
    logic [15:0] fieldbusCtrl;
    logic [31:0] fieldbusSetpoint;
    logic techCtrlActive = 1'b0;
    logic [31:0] techSetpoint = 32'h0;
    logic [31:0] actualSpeed = 32'h0;
    logic [31:0] mainSetpoint;
    logic [31:0] suppSetpoint;
    logic [31:0] speedSetpoint;
    logic overspeedAlarm;
    logic [31:0] lastSp;
    int miscompares = 0;
    int compares = 0;
    int maxStep = 0;
    int firstStep = 0;
    localparam logic [31:0] RST_VALS [8] = '{32'h2, 32'h0, 32'h0, 32'h5dc,
        32'h33450, 32'hfffccbb0, 32'h2710, 32'h2};
    localparam logic [31:0] DIR_MAIN [4] = '{32'h0, 32'h12c, 32'h7d0, 32'h8fc};
    localparam logic [31:0] DIR_TGT [4] = '{32'h0, 32'h12c, 32'h0, 32'h5dc};

    always #12.5 sys_clk = ~sys_clk;

    sps_controller_model i_sps_controller_model (.sys_clk(sys_clk),
        .wantDin(wantDin), .wantCw(wantCw), .wantSp(wantSp),
        .digitalIn(digitalIn), .fieldbusCtrl(fieldbusCtrl),
        .fieldbusSetpoint(fieldbusSetpoint));

    // The tick is shortened so that a ramp runs in a few hundred cycles.
    sps_speed_setpoint_channel #(.TICK_CYCLES(8)) i_sps_speed_setpoint_channel (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .digitalIn(digitalIn), .fieldbusCtrl(fieldbusCtrl),
        .fieldbusSetpoint(fieldbusSetpoint), .techCtrlActive(techCtrlActive),
        .techSetpoint(techSetpoint), .actualSpeed(actualSpeed),
        .mainSetpoint(mainSetpoint), .suppSetpoint(suppSetpoint),
        .speedSetpoint(speedSetpoint), .overspeedAlarm(overspeedAlarm));

    function automatic int absd(input logic [31:0] v);
        int d = $signed(v);
        return d < 0 ? -d : d;
    endfunction

    // Largest and first change of the ramp output, to see its rate limit.
    always @(posedge sys_clk)
    begin
        lastSp <= speedSetpoint;
        if (speedSetpoint !== lastSp && firstStep == 0)
            firstStep = absd(speedSetpoint - lastSp);
        if (absd(speedSetpoint - lastSp) > maxStep)
            maxStep = absd(speedSetpoint - lastSp);
    end

    task results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            miscompares++;
            results();
        end
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic e;
        apb(1'b1, a, d, v, e);
    endtask

    task automatic chkReg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic x;
        int n = 0;
        do
        begin
            apb(1'b0, a, 32'h0, v, x);
            n++;
        end
        while (v !== e && n < 30);
        cmp($sformatf("register %h", a), e, v);
        if (v !== e)
            results();
    endtask

    function automatic logic [31:0] outv(input int k);
        case (k)
            0: return mainSetpoint;
            1: return suppSetpoint;
            2: return speedSetpoint;
            default: return {31'h0, overspeedAlarm};
        endcase
    endfunction

    task automatic expOut(input int k, input logic [31:0] e, input int b);
        int n = 0;
        while (outv(k) !== e && n < b)
        begin
            @(posedge sys_clk);
            n++;
        end
        cmp($sformatf("output %0d", k), e, outv(k));
        if (outv(k) !== e)
            results();
    endtask

    initial
    begin
        repeat (90000) @(posedge sys_clk);
        miscompares++;
        results();
    end

    initial
    begin
        logic [31:0] v;
        logic e;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 8; i++)
            chkReg(8'(4 * i), RST_VALS[i]);
        apb(1'b0, 8'h80, 32'h0, v, e);
        cmp("slverr", 32'h1, {31'h0, e});
        cmp("unmapped", 32'h0, v);
        // A main source other than fixed takes the fieldbus setpoint.
        wantSp <= 32'h1f4;
        expOut(0, 32'h1f4, 20);
        wr(sps_pkg::OFF_FIXED, 32'h12c);
        wr(sps_pkg::OFF_FIXED + 8'h4, 32'h7d0);
        wr(sps_pkg::OFF_SRC, 32'h400);
        wr(sps_pkg::OFF_CTRL, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            wantDin <= 4'(i);
            expOut(0, DIR_MAIN[i], 20);
            chkReg(sps_pkg::OFF_TARGET, DIR_TGT[i]);
        end
        // Inverting before the inhibit must give zero, not the clamped value.
        wr(sps_pkg::OFF_CTRL, 32'h21);
        chkReg(sps_pkg::OFF_TARGET, -32'h5dc);
        wantDin <= 4'h1;
        chkReg(sps_pkg::OFF_TARGET, 32'h12c);
        wantDin <= 4'h3;
        wr(sps_pkg::OFF_CTRL, 32'h25);
        chkReg(sps_pkg::OFF_TARGET, 32'h0);
        wr(sps_pkg::OFF_SRC, 32'h0400_0400);
        wr(sps_pkg::OFF_CTRL, 32'hf40);
        for (int i = 1; i < 16; i++)
            wr(sps_pkg::OFF_FIXED + 8'(4 * i), 32'(50 * i));
        for (int i = 0; i < 16; i++)
        begin
            wantCw <= 16'(i);
            expOut(0, i == 0 ? 32'h12c : 32'(50 * i), 20);
            expOut(1, i == 0 ? 32'h12c : 32'(50 * i), 20);
        end
        wr(sps_pkg::OFF_SRC, 32'h400);
        expOut(1, 32'h0, 20);
        wantCw <= 16'h0803;
        wr(sps_pkg::OFF_CTRL, 32'hf70);
        chkReg(sps_pkg::OFF_TARGET, -32'h96);
        wantCw <= 16'h0003;
        chkReg(sps_pkg::OFF_TARGET, 32'h96);
        wr(sps_pkg::OFF_CTRL, 32'hf78);
        chkReg(sps_pkg::OFF_TARGET, 32'h0);
        wr(sps_pkg::OFF_CTRL, 32'hf70);
        wr(sps_pkg::OFF_MIN, 32'hc8);
        chkReg(sps_pkg::OFF_TARGET, 32'hc8);
        wantCw <= 16'h0803;
        chkReg(sps_pkg::OFF_TARGET, -32'hc8);
        wr(sps_pkg::OFF_NEGLIM, -32'hbe);
        chkReg(sps_pkg::OFF_TARGET, -32'hbe);
        wantCw <= 16'h0003;
        wr(sps_pkg::OFF_POSLIM, 32'hb4);
        chkReg(sps_pkg::OFF_TARGET, 32'hb4);
        wr(sps_pkg::OFF_MIN, 32'h0);
        wr(sps_pkg::OFF_POSLIM, 32'h33450);
        wr(sps_pkg::OFF_NEGLIM, 32'hfffccbb0);
        // A 10 ms ramp-up at 1500 rpm gives exactly 150 rpm per tick.
        wr(sps_pkg::OFF_RAMPUP, 32'ha);
        wr(sps_pkg::OFF_CTRL, 32'hf40);
        wantCw <= 16'h0;
        expOut(2, 32'h0, 600);
        repeat (60) @(posedge sys_clk);
        maxStep = 0;
        firstStep = 0;
        wantCw <= 16'h0007;
        expOut(2, 32'h15e, 600);
        cmp("step", 32'h96, 32'(maxStep));
        cmp("first step", 32'h96, 32'(firstStep));
        wr(sps_pkg::OFF_CTRL, 32'hf42);
        maxStep = 0;
        firstStep = 0;
        wantCw <= 16'h0;
        expOut(2, 32'h0, 2000);
        cmp("jerk", 32'h1, 32'(firstStep > 0 && firstStep < 150));
        techSetpoint <= 32'h309;
        techCtrlActive <= 1'b1;
        expOut(2, 32'h309, 6);
        techCtrlActive <= 1'b0;
        expOut(2, 32'h0, 600);
        actualSpeed <= 32'h5dc;
        repeat (4) @(posedge sys_clk);
        expOut(3, 32'h0, 0);
        // A low clock enable must hold the alarm although speed is too high.
        clkEn <= 1'b0;
        actualSpeed <= 32'h5dd;
        repeat (4) @(posedge sys_clk);
        expOut(3, 32'h0, 0);
        clkEn <= 1'b1;
        expOut(3, 32'h1, 4);
        actualSpeed <= 32'h0;
        chkReg(sps_pkg::OFF_STATUS, 32'h3);
        wr(sps_pkg::OFF_STATUS, 32'h1);
        expOut(3, 32'h0, 4);
        results();
    end
endmodule
